// ### logic/isc_pkg.sv
// constants shared by the drive socket control logic
package isc_pkg;

	// ********************************************************
	// bus geometry
	// ********************************************************
	localparam int          ADDR_W        = 30;
	localparam int          DATA_W        = 8;
	localparam int          REG_CNT       = 5;
	localparam int          IDX_W         = 3;

	// ********************************************************
	// register byte addresses
	// ********************************************************
	localparam logic [29:0] SUPPLY_STATUS_ADDR        = 30'h0200_1000;
	localparam logic [29:0] INTERFACE_DMA_CONFIG_ADDR = 30'h0200_1002;
	localparam logic [29:0] DRIVE_RESET_READY_ADDR    = 30'h0200_1004;
	localparam logic [29:0] LINE_DRIVER_ENABLES_ADDR  = 30'h0200_1006;
	localparam logic [29:0] DRIVE_POWER_CONTROL_ADDR  = 30'h0200_1008;

	localparam logic [2:0]  IDX_SUPPLY    = 3'h0;
	localparam logic [2:0]  IDX_IFDMA     = 3'h1;
	localparam logic [2:0]  IDX_RSTRDY    = 3'h2;
	localparam logic [2:0]  IDX_BUFEN     = 3'h3;
	localparam logic [2:0]  IDX_POWER     = 3'h4;
	localparam logic [2:0]  IDX_NONE      = 3'h7;

	// ********************************************************
	// drive socket areas
	// ********************************************************
	localparam logic [29:0] AREA0_BASE    = 30'h2000_0000;
	localparam logic [29:0] AREA1_BASE    = 30'h2000_0800;
	localparam int          AREA_SPAN_LSB = 12;
	localparam int          AREA_SEL_BIT  = 11;
	localparam int          DMA_ACK_HI_BIT = 21;
	localparam int          DMA_ACK_LO_BIT = 13;

	// ********************************************************
	// field positions
	// ********************************************************
	localparam int          BIT_BOARD_SUPPLY_GOOD  = 2;
	localparam int          BIT_TRUE_DISK_MODE     = 0;
	localparam int          BIT_DMA_MODE_ENABLE    = 2;
	localparam int          BIT_DMA_CHANNEL_SELECT = 3;
	localparam int          BIT_DRIVE_RESET_N      = 1;
	localparam int          BIT_DRIVE_READY        = 3;
	localparam int          BIT_DATA_BUF_EN        = 0;
	localparam int          BIT_ADDR_CTRL_BUF_EN   = 1;
	localparam int          BIT_INPUT_BUF_EN       = 2;
	localparam int          BIT_DRIVE_POWER_ENABLE = 0;
	localparam int          BIT_SUPPLY_VOLT_SELECT = 1;
	localparam int          BIT_DRIVE_POWER_GOOD   = 3;

	// ********************************************************
	// reset values
	// ********************************************************
	localparam logic        RST_DMA_MODE_ENABLE    = 1'h0;
	localparam logic        RST_DMA_CHANNEL_SELECT = 1'h0;
	localparam logic        RST_DRIVE_RESET_N      = 1'h0;
	localparam logic [2:0]  RST_BUF_EN             = 3'h0;
	localparam logic        RST_DRIVE_POWER_ENABLE = 1'h0;

	// ********************************************************
	// bus access sequencer
	// ********************************************************
	typedef enum logic [2:0] {
		ACC_IDLE = 3'b001,
		ACC_RD   = 3'b010,
		ACC_WR   = 3'b100
	} isc_acc_t;

endpackage : isc_pkg

// ### logic/isc_cfg_if.sv
// configuration carried from the register store to the socket steering
`timescale 1ns/1ns
interface isc_cfg_if;
	logic       dma_mode_enable;
	logic       dma_channel_select;
	logic       drive_reset_n;
	logic [2:0] buf_en;
	logic       drive_power_enable;

	modport store (
		output dma_mode_enable,
		output dma_channel_select,
		output drive_reset_n,
		output buf_en,
		output drive_power_enable
	);
	modport user (
		input  dma_mode_enable,
		input  dma_channel_select,
		input  drive_reset_n,
		input  buf_en,
		input  drive_power_enable
	);
endinterface : isc_cfg_if

// ### logic/isc_regs.sv
// writable register bits of the drive socket control
`timescale 1ns/1ns
module isc_regs (
	input  wire logic                       clk,
	input  wire logic                       arst_n,
	input  wire logic                       wr_stb,
	input  wire logic [2:0]                 wr_idx,
	input  wire logic [isc_pkg::DATA_W-1:0] wr_data,
	isc_cfg_if.store                        cfg
);
	logic       dma_en_r;
	logic       dma_ch_r;
	logic       rst_n_r;
	logic [2:0] buf_en_r;
	logic       pwr_r;

	wire wr_ifdma  = wr_stb && (wr_idx == isc_pkg::IDX_IFDMA);
	wire wr_rstrdy = wr_stb && (wr_idx == isc_pkg::IDX_RSTRDY);
	wire wr_bufen  = wr_stb && (wr_idx == isc_pkg::IDX_BUFEN);
	wire wr_power  = wr_stb && (wr_idx == isc_pkg::IDX_POWER);

	// only the documented writable bits are stored; the rest drop writes
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			dma_en_r <= isc_pkg::RST_DMA_MODE_ENABLE;
			dma_ch_r <= isc_pkg::RST_DMA_CHANNEL_SELECT;
			rst_n_r  <= isc_pkg::RST_DRIVE_RESET_N;
			buf_en_r <= isc_pkg::RST_BUF_EN;
			pwr_r    <= isc_pkg::RST_DRIVE_POWER_ENABLE;
		end else begin
			if (wr_ifdma) begin
				dma_en_r <= wr_data[isc_pkg::BIT_DMA_MODE_ENABLE];
				dma_ch_r <= wr_data[isc_pkg::BIT_DMA_CHANNEL_SELECT];
			end
			if (wr_rstrdy)
				rst_n_r <= wr_data[isc_pkg::BIT_DRIVE_RESET_N];
			if (wr_bufen)
				buf_en_r <= wr_data[2:0];
			if (wr_power)
				pwr_r <= wr_data[isc_pkg::BIT_DRIVE_POWER_ENABLE];
		end
	end

	assign cfg.dma_mode_enable    = dma_en_r;
	assign cfg.dma_channel_select = dma_ch_r;
	assign cfg.drive_reset_n      = rst_n_r;
	assign cfg.buf_en             = buf_en_r;
	assign cfg.drive_power_enable = pwr_r;
endmodule : isc_regs

// ### logic/isc_steer.sv
// card select steering and dma acknowledge for the drive socket
`timescale 1ns/1ns
module isc_steer (
	input  wire logic                       sock_access,
	input  wire logic [isc_pkg::ADDR_W-1:0] addr,
	isc_cfg_if.user                         cfg,
	output logic                            card_select_area0_n,
	output logic                            card_select_area1_n,
	output logic                            dma_acknowledge
);
	// the socket window covers both 2 KB areas; a11 picks one of them
	wire in_window = (addr[isc_pkg::ADDR_W-1:isc_pkg::AREA_SPAN_LSB]
	                  == isc_pkg::AREA0_BASE[isc_pkg::ADDR_W-1:isc_pkg::AREA_SPAN_LSB]);
	wire hit       = sock_access && in_window;
	wire pick_hi   = addr[isc_pkg::AREA_SEL_BIT];

	// width strobes are not looked at, so byte and halfword cycles select alike
	assign card_select_area0_n = !(hit && !pick_hi);
	assign card_select_area1_n = !(hit && pick_hi);

	// dma acknowledge is a separate decode, independent of the socket window
	assign dma_acknowledge = sock_access && cfg.dma_mode_enable
	                         && addr[isc_pkg::DMA_ACK_HI_BIT]
	                         && !addr[isc_pkg::DMA_ACK_LO_BIT];
endmodule : isc_steer

// ### logic/isc_top.sv
// drive socket control block: register port, card selects and dma acknowledge
`timescale 1ns/1ns
module isc_top (
	input  wire logic                       clk,
	input  wire logic                       arst_n,
	input  wire logic [isc_pkg::ADDR_W-1:0] bus_addr,
	input  wire logic                       reg_sel_n,
	input  wire logic                       sock_sel_n,
	input  wire logic                       bus_rd_n,
	input  wire logic                       bus_wr_n,
	input  wire logic [isc_pkg::DATA_W-1:0] bus_data_in,
	output logic      [isc_pkg::DATA_W-1:0] bus_data_out,
	output logic                            bus_data_oe,
	input  wire logic                       board_supply_good,
	input  wire logic                       drive_ready,
	input  wire logic                       drive_power_good,
	output logic                            card_select_area0_n,
	output logic                            card_select_area1_n,
	output logic                            dma_acknowledge,
	output logic                            dma_mode_enable,
	output logic                            dma_channel_select,
	output logic                            drive_reset_n,
	output logic                            data_buffer_enable,
	output logic                            addr_ctrl_buffer_enable,
	output logic                            input_buffer_enable,
	output logic                            drive_power_enable,
	output logic                            true_disk_mode_select,
	output logic                            supply_voltage_select
);
	// ********************************************************
	// address decode
	// ********************************************************
	// odd addresses and unmapped words resolve to no register
	function automatic logic [2:0] reg_index(input logic [isc_pkg::ADDR_W-1:0] a);
		logic [2:0] idx;
		idx = isc_pkg::IDX_NONE;
		if (a == isc_pkg::SUPPLY_STATUS_ADDR)
			idx = isc_pkg::IDX_SUPPLY;
		else if (a == isc_pkg::INTERFACE_DMA_CONFIG_ADDR)
			idx = isc_pkg::IDX_IFDMA;
		else if (a == isc_pkg::DRIVE_RESET_READY_ADDR)
			idx = isc_pkg::IDX_RSTRDY;
		else if (a == isc_pkg::LINE_DRIVER_ENABLES_ADDR)
			idx = isc_pkg::IDX_BUFEN;
		else if (a == isc_pkg::DRIVE_POWER_CONTROL_ADDR)
			idx = isc_pkg::IDX_POWER;
		return idx;
	endfunction : reg_index

	wire [2:0] acc_idx  = reg_index(bus_addr);
	wire       reg_rd   = !reg_sel_n && !bus_rd_n && bus_wr_n;
	wire       reg_wr   = !reg_sel_n && !bus_wr_n && bus_rd_n;
	wire       sock_acc = !sock_sel_n && (!bus_rd_n || !bus_wr_n);

	// ********************************************************
	// access sequencer
	// ********************************************************
	// a write strobe may last many clocks; storing once per strobe keeps
	// side effects single even if a future bit gains write-to-act meaning
	isc_pkg::isc_acc_t acc_r;
	isc_pkg::isc_acc_t acc_nxt;

	always_comb begin
		acc_nxt = acc_r;
		case (acc_r)
			isc_pkg::ACC_IDLE: begin
				if (reg_wr)
					acc_nxt = isc_pkg::ACC_WR;
				else if (reg_rd)
					acc_nxt = isc_pkg::ACC_RD;
			end
			isc_pkg::ACC_RD: begin
				if (!reg_rd)
					acc_nxt = isc_pkg::ACC_IDLE;
			end
			isc_pkg::ACC_WR: begin
				if (!reg_wr)
					acc_nxt = isc_pkg::ACC_IDLE;
			end
			default: acc_nxt = isc_pkg::ACC_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			acc_r <= isc_pkg::ACC_IDLE;
		else
			acc_r <= acc_nxt;
	end

	wire wr_stb = reg_wr && (acc_r == isc_pkg::ACC_IDLE);

	// ********************************************************
	// register store and steering
	// ********************************************************
	isc_cfg_if cfg ();

	isc_regs u_regs (
		.clk     (clk),
		.arst_n  (arst_n),
		.wr_stb  (wr_stb),
		.wr_idx  (acc_idx),
		.wr_data (bus_data_in),
		.cfg     (cfg.store)
	);

	isc_steer u_steer (
		.sock_access         (sock_acc),
		.addr                (bus_addr),
		.cfg                 (cfg.user),
		.card_select_area0_n (card_select_area0_n),
		.card_select_area1_n (card_select_area1_n),
		.dma_acknowledge     (dma_acknowledge)
	);

	// ********************************************************
	// read data
	// ********************************************************
	logic [isc_pkg::DATA_W-1:0] rd_mux;

	always_comb begin
		rd_mux = '0;
		if (acc_idx == isc_pkg::IDX_SUPPLY) begin
			rd_mux[isc_pkg::BIT_BOARD_SUPPLY_GOOD] = board_supply_good;
		end else if (acc_idx == isc_pkg::IDX_IFDMA) begin
			rd_mux[isc_pkg::BIT_TRUE_DISK_MODE]     = 1'b1;
			rd_mux[isc_pkg::BIT_DMA_MODE_ENABLE]    = cfg.dma_mode_enable;
			rd_mux[isc_pkg::BIT_DMA_CHANNEL_SELECT] = cfg.dma_channel_select;
		end else if (acc_idx == isc_pkg::IDX_RSTRDY) begin
			rd_mux[isc_pkg::BIT_DRIVE_RESET_N] = cfg.drive_reset_n;
			rd_mux[isc_pkg::BIT_DRIVE_READY]   = drive_ready;
		end else if (acc_idx == isc_pkg::IDX_BUFEN) begin
			rd_mux[2:0] = cfg.buf_en;
		end else if (acc_idx == isc_pkg::IDX_POWER) begin
			rd_mux[isc_pkg::BIT_DRIVE_POWER_ENABLE] = cfg.drive_power_enable;
			rd_mux[isc_pkg::BIT_SUPPLY_VOLT_SELECT] = 1'b1;
			rd_mux[isc_pkg::BIT_DRIVE_POWER_GOOD]   = drive_power_good;
		end
	end

	// status inputs are sampled every cycle of the read so a long strobe sees live levels
	logic [isc_pkg::DATA_W-1:0] rdata_r;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			rdata_r <= '0;
		else if (reg_rd)
			rdata_r <= rd_mux;
	end

	// data is valid from the second clock of a read strobe
	assign bus_data_out = rdata_r;
	assign bus_data_oe  = reg_rd && (acc_r == isc_pkg::ACC_RD);

	// ********************************************************
	// board outputs
	// ********************************************************
	assign dma_mode_enable         = cfg.dma_mode_enable;
	assign dma_channel_select      = cfg.dma_channel_select;
	assign drive_reset_n           = cfg.drive_reset_n;
	assign data_buffer_enable      = cfg.buf_en[isc_pkg::BIT_DATA_BUF_EN];
	assign addr_ctrl_buffer_enable = cfg.buf_en[isc_pkg::BIT_ADDR_CTRL_BUF_EN];
	assign input_buffer_enable     = cfg.buf_en[isc_pkg::BIT_INPUT_BUF_EN];
	assign drive_power_enable      = cfg.drive_power_enable;
	// fixed straps: memory mode and 3 V supply cannot be chosen for this socket
	assign true_disk_mode_select   = 1'b1;
	assign supply_voltage_select   = 1'b1;
endmodule : isc_top

// ### tb/isc_top_monitor.sv
// port assertions for the drive socket control block
`timescale 1ns/1ns
module isc_top_monitor (
	input wire logic        clk,
	input wire logic        arst_n,
	input wire logic [29:0] bus_addr,
	input wire logic        reg_sel_n,
	input wire logic        sock_sel_n,
	input wire logic        bus_rd_n,
	input wire logic        bus_wr_n,
	input wire logic [7:0]  bus_data_in,
	input wire logic        bus_data_oe,
	input wire logic        card_select_area0_n,
	input wire logic        card_select_area1_n,
	input wire logic        dma_acknowledge,
	input wire logic        dma_mode_enable,
	input wire logic        dma_channel_select,
	input wire logic        drive_reset_n,
	input wire logic        drive_power_enable,
	input wire logic        true_disk_mode_select,
	input wire logic        supply_voltage_select
);
	// ********************************
	// helper terms
	// ********************************
	wire       acc = !sock_sel_n && (!bus_rd_n || !bus_wr_n);
	wire       win = bus_addr[29:12] == isc_pkg::AREA0_BASE[29:12];
	wire       rwr = !reg_sel_n && !bus_wr_n && bus_rd_n;
	wire       rrd = !reg_sel_n && !bus_rd_n && bus_wr_n;
	wire       dak = acc && dma_mode_enable && bus_addr[21] && !bus_addr[13];
	wire [3:0] cfg = {dma_mode_enable, dma_channel_select, drive_reset_n, drive_power_enable};
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	AST_SEL_EXCL: assert property (card_select_area0_n || card_select_area1_n)
		else $error("both card selects active");
	AST_AREA0: assert property (acc && win && !bus_addr[11] |-> !card_select_area0_n && card_select_area1_n)
		else $error("area 0 select wrong");
	AST_AREA1: assert property (acc && win && bus_addr[11] |-> card_select_area0_n && !card_select_area1_n)
		else $error("area 1 select wrong");
	AST_DMA_ACKNOWLEDGE: assert property (dma_acknowledge == dak)
		else $error("dma acknowledge decode wrong");
	AST_FIXED: assert property (true_disk_mode_select && supply_voltage_select)
		else $error("fixed mode bits not high");
	AST_RD_OE: assert property (rrd && $past(reg_sel_n || bus_rd_n) |=> bus_data_oe)
		else $error("read answer missing");
	AST_OE_OFF: assert property (reg_sel_n || bus_rd_n |-> !bus_data_oe)
		else $error("data driven without read");
	AST_RST_WR: assert property (rwr && bus_addr == isc_pkg::DRIVE_RESET_READY_ADDR
		|=> drive_reset_n == $past(bus_data_in[1]))
		else $error("drive reset bit not stored");
	AST_HOLD: assert property (!rwr |=> $stable(cfg))
		else $error("config changed without write");
	COV_AREA1: cover property (acc && !card_select_area1_n);
	COV_DMA_ACKNOWLEDGE: cover property (dma_acknowledge);
	COV_READ: cover property (rrd ##1 bus_data_oe);
endmodule : isc_top_monitor

bind isc_top isc_top_monitor i_mon (.clk, .arst_n, .bus_addr, .reg_sel_n, .sock_sel_n, .bus_rd_n,
	.bus_wr_n, .bus_data_in, .bus_data_oe, .card_select_area0_n, .card_select_area1_n, .dma_acknowledge,
	.dma_mode_enable, .dma_channel_select, .drive_reset_n, .drive_power_enable, .true_disk_mode_select,
	.supply_voltage_select);

// ### tb/isc_host_model.sv
// host bus master for the register and socket strobes
`timescale 1ns/1ns
module isc_host_model (
	input  wire logic        clk,
	input  wire logic [7:0]  bus_data_out,
	input  wire logic        bus_data_oe,
	output logic      [29:0] bus_addr,
	output logic             reg_sel_n,
	output logic             sock_sel_n,
	output logic             bus_rd_n,
	output logic             bus_wr_n,
	output logic      [7:0]  bus_data_in,
	output logic             tmo
);
	initial begin
		bus_addr = '0;
		{reg_sel_n, sock_sel_n, bus_rd_n, bus_wr_n} = 4'hF;
		bus_data_in = 8'h00;
		tmo = 1'b0;
	end
	// one strobe cycle then one idle cycle, so writes never merge
	task automatic wr(input logic [29:0] a, input logic [7:0] d);
		bus_addr <= a;
		bus_data_in <= d;
		{reg_sel_n, bus_wr_n} <= 2'h0;
		@(posedge clk);
		{reg_sel_n, bus_wr_n} <= 2'h3;
		bus_data_in <= ~d;
		@(posedge clk);
	endtask : wr
	// strobe held until the answer is sampled, bounded wait
	task automatic rd(input logic [29:0] a, output logic [7:0] d);
		bit ok;
		ok = 1'b0;
		d = 8'h00;
		bus_addr <= a;
		{reg_sel_n, bus_rd_n} <= 2'h0;
		for (int n = 0; n < 8 && !ok; n++) begin
			@(posedge clk);
			if (bus_data_oe === 1'b1) begin
				d = bus_data_out;
				ok = 1'b1;
			end
		end
		tmo = !ok;
		{reg_sel_n, bus_rd_n} <= 2'h3;
		@(posedge clk);
	endtask : rd
	// socket access: write when w is 1, read when w is 0, register select untouched
	task automatic sk(input logic [29:0] a, input logic w);
		bus_addr <= a;
		sock_sel_n <= 1'b0;
		{bus_rd_n, bus_wr_n} <= {w, !w};
		@(posedge clk);
	endtask : sk
	task automatic rel();
		{sock_sel_n, bus_rd_n, bus_wr_n} <= 3'h7;
		@(posedge clk);
	endtask : rel
endmodule : isc_host_model

// ### tb/isc_top_tb.sv
// self-checking bench for the drive socket control block
`timescale 1ns/1ns
module isc_top_tb;
	logic        clk, arst_n, reg_sel_n, sock_sel_n, bus_rd_n, bus_wr_n, bus_data_oe, tmo;
	logic [29:0] bus_addr;
	logic [7:0]  bus_data_in, bus_data_out;
	logic        board_supply_good, drive_ready, drive_power_good;
	logic        card_select_area0_n, card_select_area1_n, dma_acknowledge, dma_mode_enable;
	logic        dma_channel_select, drive_reset_n, data_buffer_enable, addr_ctrl_buffer_enable;
	logic        input_buffer_enable, drive_power_enable, true_disk_mode_select, supply_voltage_select;
	int          num_errors, n_compared;
	localparam logic [29:0] RA [5] = '{isc_pkg::SUPPLY_STATUS_ADDR, isc_pkg::INTERFACE_DMA_CONFIG_ADDR,
		isc_pkg::DRIVE_RESET_READY_ADDR, isc_pkg::LINE_DRIVER_ENABLES_ADDR, isc_pkg::DRIVE_POWER_CONTROL_ADDR};
	localparam logic [29:0] SA [7] = '{30'h2000_0000, 30'h2000_0801, 30'h2000_0FFF, 30'h2000_07FE,
		30'h2020_0000, 30'h2020_2000, 30'h0000_0000};
	localparam logic [7:0]  PAT [4] = '{8'h5A, 8'hA5, 8'hFF, 8'h00};
	wire [7:0] pins = {true_disk_mode_select, dma_mode_enable, dma_channel_select, drive_reset_n,
		input_buffer_enable, addr_ctrl_buffer_enable, data_buffer_enable, drive_power_enable};

	isc_host_model i_host (.clk, .bus_data_out, .bus_data_oe, .bus_addr, .reg_sel_n, .sock_sel_n,
		.bus_rd_n, .bus_wr_n, .bus_data_in, .tmo);
	isc_top i_dut (.clk, .arst_n, .bus_addr, .reg_sel_n, .sock_sel_n, .bus_rd_n, .bus_wr_n, .bus_data_in,
		.bus_data_out, .bus_data_oe, .board_supply_good, .drive_ready, .drive_power_good,
		.card_select_area0_n, .card_select_area1_n, .dma_acknowledge, .dma_mode_enable, .dma_channel_select,
		.drive_reset_n, .data_buffer_enable, .addr_ctrl_buffer_enable, .input_buffer_enable,
		.drive_power_enable, .true_disk_mode_select, .supply_voltage_select);

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// ********************************
	// checking and reporting
	// ********************************
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected at %0t: seen 0x%0h expected 0x%0h", $time, seen, exp);
		end
	endtask : chk
	task automatic summarize();
		$display("compared %0d mismatched %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : summarize
	task automatic rc(input logic [29:0] a, input logic [7:0] exp);
		logic [7:0] d;
		i_host.rd(a, d);
		if (tmo) begin
			num_errors++;
			summarize();
		end else begin
			chk(d, exp);
		end
	endtask : rc
	// read value after writing d, status bits live from the inputs
	function automatic logic [7:0] ev(input int i, input logic [7:0] d);
		case (i)
			0: ev = {5'h00, board_supply_good, 2'h0};
			1: ev = {4'h0, d[3], d[2], 2'h1};
			2: ev = {4'h0, drive_ready, 1'h0, d[1], 1'h0};
			3: ev = {5'h00, d[2:0]};
			default: ev = {4'h0, drive_power_good, 2'h1, d[0]};
		endcase
	endfunction : ev
	// ********************************
	// main sequence
	// ********************************
	initial begin
		logic [29:0] a;
		logic        win;
		arst_n = 1'b0;
		{board_supply_good, drive_ready, drive_power_good} = 3'h4;
		num_errors = 0;
		n_compared = 0;
		repeat (20) @(posedge clk);
		arst_n <= 1'b1;
		@(posedge clk);
		chk(pins, 8'h80);
		chk({7'h00, supply_voltage_select}, 8'h01);
		for (int i = 0; i < 5; i++) rc(RA[i], ev(i, 8'h00));
		{drive_ready, drive_power_good} <= 2'h3;
		foreach (PAT[p]) begin
			for (int i = 0; i < 5; i++) i_host.wr(RA[i], PAT[p]);
			for (int i = 0; i < 5; i++) rc(RA[i], ev(i, PAT[p]));
			chk(pins, {1'b1, PAT[p][2], PAT[p][3], PAT[p][1], PAT[p][2:0], PAT[p][0]});
		end
		// odd and unmapped places are ignored; the unmapped one is read back as zero
		i_host.wr(30'h0200_1003, 8'hFF);
		i_host.wr(30'h0200_100A, 8'hFF);
		chk(pins, 8'h80);
		rc(30'h0200_100A, 8'h00);
		{board_supply_good, drive_ready, drive_power_good} <= 3'h0;
		@(posedge clk);
		for (int i = 0; i < 5; i++) rc(RA[i], ev(i, 8'h00));
		for (int e = 0; e < 2; e++) begin
			i_host.wr(RA[1], e ? 8'h04 : 8'h00);
			for (int i = 0; i < 7; i++) begin
				a = SA[i];
				win = a[29:12] == 18'h20000;
				i_host.sk(a, i[0]);
				chk({5'h00, card_select_area0_n, card_select_area1_n, dma_acknowledge},
					{5'h00, !(win && !a[11]), !(win && a[11]), e == 1 && a[21] && !a[13]});
				i_host.rel();
			end
		end
		summarize();
	end
endmodule : isc_top_tb
